// >>> src/speed_doubler_map.vh
// Register offset, field positions and timing counts of the speed doubler
`ifndef SPEED_DOUBLER_MAP_VH
`define SPEED_DOUBLER_MAP_VH
`define SPEED_SELECT_CONTROL_ADDR 8'h8F
`define SPEED_SELECT_CONTROL_RESET 8'h00
`define CPU_DOUBLE_SPEED_BIT 0
`define TIMER_ZERO_SPEED_SELECT_BIT 1
`define TIMER_ONE_SPEED_SELECT_BIT 2
`define TIMER_TWO_SPEED_SELECT_BIT 3
`define SERIAL_SPEED_SELECT_BIT 4
`define COUNTER_ARRAY_SPEED_SELECT_BIT 5
`define WATCHDOG_SPEED_SELECT_BIT 6
`define CAN_SPEED_SELECT_BIT 7
`define PERIPHERAL_COUNT 7
`define STD_PERIODS_PER_CYCLE 4'hC
`define X2_PERIODS_PER_CYCLE 4'h6
`define CRYSTAL_DIVIDE_RATIO 2
`endif

// >>> src/cycle_pulse_gen.v
// Machine cycle pulse generator with standard or doubled speed
`timescale 1ns/100ps
module cycle_pulse_gen
(
  input wire ref_clk, // Crystal rate clock
  input wire rst, // Synchronous reset
  input wire half_edge, // Rising edge of halved crystal clock
  input wire fast, // Six periods per cycle when high
  output reg cycle_pulse // One pulse per machine cycle
);
`include "speed_doubler_map.vh"

  reg [3:0] count_q;
  wire [3:0] limit;

  assign limit = fast ? `X2_PERIODS_PER_CYCLE : `STD_PERIODS_PER_CYCLE;

  // Counting crystal periods keeps the divided rate exact in both modes
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      count_q <= 4'h0;
      cycle_pulse <= 1'b0;
    end
    else if (count_q >= limit - 4'h1)
    begin
      // Standard mode wraps only on a halved-clock edge so the phase stays aligned; fast mode wraps at once
      if (half_edge || fast)
      begin
        count_q <= 4'h0;
        cycle_pulse <= 1'b1;
      end
      else
      begin
        count_q <= count_q + 4'h1;
        cycle_pulse <= 1'b0;
      end
    end
    else
    begin
      count_q <= count_q + 4'h1;
      cycle_pulse <= 1'b0;
    end
  end
endmodule // cycle_pulse_gen

// >>> src/core_peripheral_speed_doubler.v
// Core and peripheral speed doubler with its clock control register
// Overview of operation
// - The CPU speed bit selects 12 or 6 clock periods per machine cycle.
// - After reset the CPU speed bit is clear unless the boot option is set.
// - The CPU speed bit alone moves the CPU and every peripheral with a clear select bit to double speed.
// - Each peripheral runs double speed only when its select bit is clear.
// - A software defeatable divide-by-2 stage follows the crystal input.
// - Standard mode uses the halved crystal; double speed bypasses it.
// - A CPU speed bit change takes effect only on a halved clock rising edge; peripheral select bits act at once.
// - A non-volatile option makes the device start in double speed.
// - A doubled peripheral sees its time base halved.
// - Only SFRs at addresses ending 0 or 8 are bit-addressable.
// - Peripheral select bits have no effect while the CPU bit is clear.
// - With the CPU bit set, select set gives 12 periods, clear gives 6.
`timescale 1ns/100ps
module core_peripheral_speed_doubler
(
  input wire ref_clk, // Crystal input rate clock
  input wire rst, // Synchronous reset, active high
  input wire boot_fast_option, // Non-volatile start-in-double-speed bit
  input wire [7:0] sfr_addr, // SFR byte address
  input wire [7:0] sfr_wdata, // SFR write data
  input wire sfr_wr, // SFR byte write strobe
  input wire sfr_rd, // SFR byte read strobe
  input wire sfr_bit_wr, // SFR bit write strobe
  input wire [7:0] sfr_bit_addr, // Bit address for bit writes
  input wire sfr_bit_val, // Bit value for bit writes
  output reg [7:0] sfr_rdata, // Read data, zero when not selected
  output reg sfr_rsel, // Read hit on this register
  output reg [7:0] speed_select_control, // Register contents
  output reg cpu_double_active, // Effective CPU double-speed state
  output reg cpu_cycle_en, // One pulse per CPU machine cycle
  output reg [6:0] periph_cycle_en // Pulse per cycle, per peripheral
);
`include "speed_doubler_map.vh"

  reg [7:0] ctrl_q;
  reg [7:0] ctrl_d;
  reg half_q;
  reg x2_q;
  reg boot_done_q;
  wire half_edge;
  wire cpu_pulse;
  wire [6:0] periph_pulse;
  wire [6:0] periph_fast;

  // Divide-by-2 stage; its rising edge gates mode changes
  always @(posedge ref_clk)
  begin
    if (rst)
      half_q <= 1'b0;
    else
      half_q <= ~half_q;
  end

  assign half_edge = ~half_q;

  // Byte writes only: this address does not end in 0 or 8, so bit
  // writes never reach it even when their range covers 0x88..0x8F
  always @*
  begin
    ctrl_d = ctrl_q;
    if (sfr_wr && sfr_addr == `SPEED_SELECT_CONTROL_ADDR)
      ctrl_d = sfr_wdata;
  end

  // The boot option is sampled in the first cycle after reset release
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_q <= `SPEED_SELECT_CONTROL_RESET;
      boot_done_q <= 1'b0;
    end
    else if (!boot_done_q)
    begin
      boot_done_q <= 1'b1;
      ctrl_q <= ctrl_d;
      if (boot_fast_option)
        ctrl_q[`CPU_DOUBLE_SPEED_BIT] <= 1'b1;
    end
    else
      ctrl_q <= ctrl_d;
  end

  // Speed bit is validated only on a halved clock rising edge
  always @(posedge ref_clk)
  begin
    if (rst)
      x2_q <= 1'b0;
    else if (half_edge)
      x2_q <= ctrl_q[`CPU_DOUBLE_SPEED_BIT];
  end

  // CPU cycle: bypasses the divider in double speed
  cycle_pulse_gen u_cpu
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .half_edge(half_edge),
    .fast(x2_q),
    .cycle_pulse(cpu_pulse)
  );

  // Enables rather than gated clocks keep peripheral state intact
  genvar i;
  generate
    for (i = 0; i < `PERIPHERAL_COUNT; i = i + 1)
    begin : g_periph
      assign periph_fast[i] = x2_q & ~ctrl_q[i + 1];
      cycle_pulse_gen u_periph
      (
        .ref_clk(ref_clk),
        .rst(rst),
        .half_edge(half_edge),
        .fast(periph_fast[i]),
        .cycle_pulse(periph_pulse[i])
      );
    end
  endgenerate

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sfr_rdata <= 8'h00;
      sfr_rsel <= 1'b0;
      speed_select_control <= 8'h00;
      cpu_double_active <= 1'b0;
      cpu_cycle_en <= 1'b0;
      periph_cycle_en <= 7'h00;
    end
    else
    begin
      if (sfr_rd && sfr_addr == `SPEED_SELECT_CONTROL_ADDR)
      begin
        sfr_rdata <= ctrl_q;
        sfr_rsel <= 1'b1;
      end
      else
      begin
        sfr_rdata <= 8'h00;
        sfr_rsel <= 1'b0;
      end
      speed_select_control <= ctrl_q;
      cpu_double_active <= x2_q;
      cpu_cycle_en <= cpu_pulse;
      periph_cycle_en <= periph_pulse;
    end
  end
endmodule // core_peripheral_speed_doubler

// >>> verification/speed_doubler_checker.sv
// Port assertions for the speed doubler
`timescale 1ns/100ps
module speed_doubler_checker
(
  input wire ref_clk, // Clock
  input wire rst, // Reset
  input wire [7:0] sfr_addr, // Address
  input wire [7:0] sfr_wdata, // Write data
  input wire sfr_wr, // Write
  input wire sfr_rd, // Read
  input wire [7:0] sfr_rdata, // Read data
  input wire sfr_rsel, // Read hit
  input wire [7:0] speed_select_control, // Register
  input wire cpu_double_active, // Fast
  input wire cpu_cycle_en, // CPU pulse
  input wire [6:0] periph_cycle_en // Peripheral pulses
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire hit_rd = sfr_rd && sfr_addr == 8'h8F;
  wire hit_wr = sfr_wr && sfr_addr == 8'h8F;
  read_hit_a: assert property (hit_rd |=> sfr_rsel &&
    sfr_rdata == speed_select_control) else $error("read data wrong");
  write_data_a: assert property (hit_wr |=> ##1
    speed_select_control[7:1] == $past(sfr_wdata[7:1], 2))
    else $error("write lost");
  reg_hold_a: assert property (!hit_wr && !$past(rst) |=> ##1
    $stable(speed_select_control)) else $error("register changed");
  reset_clear_a: assert property (disable iff (1'b0) rst |=>
    speed_select_control == 8'h00 && !cpu_double_active)
    else $error("reset state wrong");
  cpu_gap_a: assert property (cpu_cycle_en |=>
    (!cpu_cycle_en)[*5]) else $error("cpu cycle too short");
  // A switch to double speed may legally shorten the cycle in flight
  cpu_std_a: assert property (cpu_cycle_en && !cpu_double_active |=>
    (!cpu_cycle_en || cpu_double_active)[*8])
    else $error("standard cycle too short");
  periph_std_a: assert property (periph_cycle_en[0] &&
    !cpu_double_active |=> (!periph_cycle_en[0] || cpu_double_active)[*8])
    else $error("peripheral fast in standard mode");
  mode_follow_a: assert property (!$stable(cpu_double_active) |->
    cpu_double_active == $past(speed_select_control[0]))
    else $error("speed change without request");
endmodule // speed_doubler_checker

// >>> verification/tb.sv
// Testbench for the core and peripheral speed doubler
`timescale 1ns/100ps
module tb;
  reg ref_clk=0, rst=1, boot_fast_option=0, sfr_wr=0, sfr_rd=0;
  reg sfr_bit_wr=0, sfr_bit_val=0;
  reg [7:0] sfr_addr=0, sfr_wdata=0, sfr_bit_addr=8'h8F;
  wire [7:0] sfr_rdata, speed_select_control;
  wire sfr_rsel, cpu_double_active, cpu_cycle_en;
  wire [6:0] periph_cycle_en;
  wire [7:0] en = {periph_cycle_en, cpu_cycle_en};
  reg [47:0] modes = 48'hAB55FEFF0100;
  reg [7:0] m;
  integer bad_count=0, checked=0, i, b;
  core_peripheral_speed_doubler i_dut(.ref_clk(ref_clk), .rst(rst),
    .boot_fast_option(boot_fast_option), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata), .sfr_rsel(sfr_rsel),
    .speed_select_control(speed_select_control),
    .cpu_double_active(cpu_double_active), .cpu_cycle_en(cpu_cycle_en),
    .periph_cycle_en(periph_cycle_en));
  initial forever #12.5 ref_clk = ~ref_clk;
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // Write d, or read and expect d when the address hits
  task acc(input w, input [7:0] a, input [7:0] d);
  begin
    @(negedge ref_clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, d};
    @(negedge ref_clk);
    {sfr_wr, sfr_rd} = 2'b00;
    if (!w) chk("rdata", sfr_rdata, a == 8'h8F ? d : 8'h00);
    if (!w) chk("rsel", {7'h00, sfr_rsel}, {7'h00, a == 8'h8F});
  end
  endtask
  // Spacing between two pulses of enable b
  task gap(input integer b, input [7:0] exp);
    integer n;
  begin
    repeat (40) if (!en[b]) @(negedge ref_clk);
    n = 1;
    @(negedge ref_clk);
    while (!en[b] && n < 40)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    chk("gap", n[7:0], exp);
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    end_sim;
  end
  initial
  begin
    repeat (3) @(negedge ref_clk);
    rst = 0;
    acc(0, 8'h8F, 8'h00);
    acc(1, 8'h8F, 8'hA5);
    sfr_bit_wr = 1;
    acc(0, 8'h8E, 8'h00);
    sfr_bit_wr = 0;
    acc(0, 8'h8F, 8'hA5);
    for (i = 0; i < 6; i = i + 1)
    begin
      m = modes[8*i +: 8];
      acc(1, 8'h8F, m);
      repeat (30) @(negedge ref_clk);
      gap(0, m[0] ? 8'h06 : 8'h0C);
      for (b = 1; b < 8; b = b + 1)
        gap(b, m[0] && !m[b] ? 8'h06 : 8'h0C);
    end
    rst = 1;
    boot_fast_option = 1;
    repeat (3) @(negedge ref_clk);
    rst = 0;
    acc(0, 8'h8F, 8'h01);
    repeat (20) @(negedge ref_clk);
    gap(0, 8'h06);
    end_sim;
  end
endmodule // tb
bind core_peripheral_speed_doubler speed_doubler_checker i_chk(
  .ref_clk(ref_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
  .sfr_rsel(sfr_rsel), .speed_select_control(speed_select_control),
  .cpu_double_active(cpu_double_active), .cpu_cycle_en(cpu_cycle_en),
  .periph_cycle_en(periph_cycle_en));
